// File: lcd_host_model.sv
`default_nettype none
module lcd_host_model
   import lcd_port_pkg::*;
(
   // Clock
   input  wire logic                   clock_i,
   // Bus toward the port
   output var lcd_port_pkg::host_in_t  host_o,
   input  wire logic [7:0]             dev_data_i,
   input  wire logic [7:0]             dev_oe_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       rs = 1'b0;
   logic       rw = 1'b0;
   logic       en = 1'b0;
   logic       drive_on = 1'b0;
   logic [7:0] drv = 8'hFF;
   logic [7:0] bus;
   // Released lines float to the pull-up level, never to the last driven value.
   assign bus = drive_on ? drv : ((dev_data_i & dev_oe_i) | ~dev_oe_i);
   assign host_o = '{register_select: rs, read_write: rw, enable: en, host_data_bus: bus};

   // Selects and data change together with the strobe rise and stay put until after the falling edge.
   task automatic pulse(input logic s, input logic r, input logic [7:0] v,
                        output logic [7:0] rd);
      @(negedge clock_i);
      rs = s;
      rw = r;
      drv = v;
      drive_on = ~r;
      en = 1'b1;
      @(posedge clock_i);
      @(posedge clock_i);
      // Sample half a cycle after the edge that updates the read register.
      @(negedge clock_i);
      rd = bus;
      en = 1'b0;
      @(negedge clock_i);
      drive_on = 1'b0;
   endtask

   task automatic xfer(input logic s, input logic r, input logic [7:0] v,
                       input logic four, output logic [7:0] rd);
      logic [7:0] hi;
      logic [7:0] lo;
      if (four) begin
         pulse(s, r, {v[7:4], 4'hF}, hi);
         pulse(s, r, {v[3:0], 4'hF}, lo);
         rd = {hi[7:4], lo[7:4]};
      end else begin
         pulse(s, r, v, rd);
      end
   endtask
endmodule
`default_nettype wire

// File: lcd_host_port.sv
`default_nettype none
// How it works
// - Select pair picks instruction write, status read, data write or data read.
// - Write-only instruction register, data write buffer and read buffer, eight bits each.
// - Every executed instruction reloads the read buffer from the final address.
// - Host writes are ignored while an instruction executes.
// - Status reads never lock registers nor start execution.
// - Eight-bit mode starts execution and raises busy on enable fall.
// - Four-bit mode moves bytes on upper lines, upper nibble first.
// - Nibble selector toggles each enable fall; busy rises after the second.
// - Any select change returns the nibble selector to upper nibble.
// - Mode pin high means standard; low unlocks page and inversion.
// - One-line mode shows display addresses 0 to 79.
// - Two-line mode shows 0 to 39 then 64 to 103.
// - Clear and home reset the address counter to zero.
// - Set-address loads the counter and selects display or glyph memory.
// - Memory accesses step the counter per direction bit; cursor shift steps it per its own right/left bit.
// - Glyph memory uses a free 7-bit counter, low six bits addressing.
// - One-line display order wraps 79 to 0 and back.
// - Two-line order jumps 39 to 64 and 103 to 0 and back.
// - Start counter seeds the scan and clears on clear or home.
// - Start counter steps on display shift and on display-memory data writes with entry shift set, same wrap order.
module lcd_host_port
   import lcd_port_pkg::*;
(
   // Clock and reset
   input  wire logic                       clock_i,
   input  wire logic                       rst_b_i,
   // Host bus
   input  wire lcd_port_pkg::host_in_t     host_i,
   output logic [7:0]                      host_data_bus_o,
   output logic [7:0]                      host_data_bus_oe_o,
   output logic                            busy_flag_o,
   // Mode strap
   input  wire logic                       feature_mode_pin_i,
   // Display configuration for refresh logic
   input  wire logic [6:0]                 refresh_addr_i,
   output logic [7:0]                      refresh_data_o,
   output lcd_port_pkg::display_cfg_t      cfg_o
);
   import lcd_port_pkg::*;

   typedef struct packed {
      phase_t     phase;
      logic [6:0] cnt;
      op_t        op;
      logic [7:0] instruction_register;
      logic [7:0] host_write_buffer;
      logic [7:0] host_read_buffer;
      logic [3:0] upper_hold;
      logic       nib_low;
      logic       en;
      logic [1:0] sel;
      logic [6:0] address_counter;
      logic [6:0] start_addr;
      logic       glyph_sel;
      logic       increment_direction;
      logic       shift_en;
      logic       bus_width_bit;
      logic       two_line;
      logic       font_tall;
      logic       page;
      logic       invert;
      logic [2:0] disp;
      logic [7:0] dout;
   } state_t;

   state_t s_q, s_d;
   logic [7:0] display_ram [DD_WORDS];
   logic [7:0] glyph_ram   [CG_WORDS];

   logic       mem_we;
   logic       mem_cg;
   logic [6:0] mem_addr;
   logic [7:0] mem_wdata;
   logic [7:0] mem_rdata;
   logic       fall;
   logic [1:0] sel_now;
   logic       sel_change;
   logic       xfer_done;
   logic [7:0] xfer_byte;
   logic       step_ac;
   logic       step_up;
   logic       extended;

   // Maps a display address onto the packed 80-word array.
   function automatic logic [6:0] dd_index(input logic [6:0] a, input logic two);
      dd_index = (two && a >= L2_FIRST) ? 7'(a - L2_OFFSET) : a;
   endfunction

   function automatic logic dd_valid(input logic [6:0] a, input logic two);
      if (two) begin
         dd_valid = (a <= L1_LAST) || (a >= L2_FIRST && a <= L2_LAST);
      end else begin
         dd_valid = (a <= ONE_LAST);
      end
   endfunction

   // Next counter value in the order given by memory type and line mode.
   function automatic logic [6:0] step(input logic [6:0] a, input logic up,
                                       input logic two, input logic cg);
      step = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
      if (!cg) begin
         if (two) begin
            if (up && a == L1_LAST) begin
               step = L2_FIRST;
            end else if (up && a == L2_LAST) begin
               step = 7'h00;
            end else if (!up && a == L2_FIRST) begin
               step = L1_LAST;
            end else if (!up && a == 7'h00) begin
               step = L2_LAST;
            end
         end else begin
            if (up && a == ONE_LAST) begin
               step = 7'h00;
            end else if (!up && a == 7'h00) begin
               step = ONE_LAST;
            end
         end
      end
   endfunction

   assign extended   = ~feature_mode_pin_i;
   assign sel_now    = {host_i.register_select, host_i.read_write};
   assign fall       = s_q.en & ~host_i.enable;
   assign sel_change = (sel_now != s_q.sel);

   // Read path shared by load phase and status of memories.
   always_comb begin
      if (mem_cg) begin
         mem_rdata = glyph_ram[mem_addr[5:0]];
      end else if (dd_valid(mem_addr, s_q.two_line)) begin
         mem_rdata = display_ram[dd_index(mem_addr, s_q.two_line)];
      end else begin
         mem_rdata = SPACE_CODE;
      end
   end

   always_comb begin
      s_d        = s_q;
      s_d.en     = host_i.enable;
      s_d.sel    = sel_now;
      xfer_done  = 1'b0;
      xfer_byte  = host_i.host_data_bus;
      mem_we     = 1'b0;
      mem_cg     = s_q.glyph_sel;
      mem_addr   = s_q.address_counter;
      mem_wdata  = s_q.host_write_buffer;
      step_ac    = 1'b0;
      step_up    = s_q.increment_direction;

      // Nibble sequencing; a select change restarts at the upper nibble.
      if (sel_change) begin
         s_d.nib_low = 1'b0;
      end
      if (fall) begin
         if (s_q.bus_width_bit) begin
            xfer_done = 1'b1;
         end else if (!s_q.nib_low || sel_change) begin
            s_d.nib_low    = 1'b1;
            s_d.upper_hold = host_i.host_data_bus[7:4];
         end else begin
            s_d.nib_low = 1'b0;
            xfer_done   = 1'b1;
            xfer_byte   = {s_q.upper_hold, host_i.host_data_bus[7:4]};
         end
      end

      case (s_q.phase)
         S_IDLE: begin
            // Status reads fall through without starting anything.
            if (xfer_done && sel_now != SEL_STATUS) begin
               s_d.phase = S_EXEC;
               s_d.cnt   = EXEC_LAST;
               case (sel_now)
                  SEL_INSTR: begin
                     s_d.op                   = OP_INSTR;
                     s_d.instruction_register = xfer_byte;
                  end
                  SEL_DWRITE: begin
                     s_d.op                = OP_DWRITE;
                     s_d.host_write_buffer = xfer_byte;
                  end
                  default: begin
                     s_d.op = OP_DREAD;
                  end
               endcase
            end
         end
         S_EXEC: begin
            // Host writes are simply not captured outside the idle phase.
            s_d.cnt = 7'(s_q.cnt - 7'h01);
            if (s_q.cnt == 7'h00) begin
               s_d.phase = S_LOAD;
               case (s_q.op)
                  OP_DWRITE: begin
                     mem_we  = mem_cg || dd_valid(mem_addr, s_q.two_line);
                     step_ac = 1'b1;
                     if (s_q.shift_en && !s_q.glyph_sel) begin
                        s_d.start_addr = step(s_q.start_addr, s_q.increment_direction,
                                              s_q.two_line, 1'b0);
                     end
                  end
                  OP_DREAD: begin
                     step_ac = 1'b1;
                  end
                  default: begin
                     if (s_q.instruction_register[B_DDADDR]) begin
                        s_d.address_counter = s_q.instruction_register[6:0];
                        s_d.glyph_sel       = 1'b0;
                     end else if (s_q.instruction_register[B_CGADDR]) begin
                        s_d.address_counter = {1'b0, s_q.instruction_register[5:0]};
                        s_d.glyph_sel       = 1'b1;
                     end else if (s_q.instruction_register[B_FUNC]) begin
                        s_d.bus_width_bit = s_q.instruction_register[4];
                        s_d.two_line      = s_q.instruction_register[3];
                        s_d.font_tall     = s_q.instruction_register[2];
                        if (extended) begin
                           s_d.page   = s_q.instruction_register[1];
                           s_d.invert = s_q.instruction_register[0];
                        end
                     end else if (s_q.instruction_register[B_SHIFT]) begin
                        if (s_q.instruction_register[3]) begin
                           s_d.start_addr = step(s_q.start_addr, s_q.instruction_register[2],
                                                 s_q.two_line, 1'b0);
                        end else begin
                           step_ac = 1'b1;
                           step_up = s_q.instruction_register[2];
                        end
                     end else if (s_q.instruction_register[B_DISP]) begin
                        s_d.disp = s_q.instruction_register[2:0];
                     end else if (s_q.instruction_register[B_ENTRY]) begin
                        s_d.increment_direction = s_q.instruction_register[1];
                        s_d.shift_en            = s_q.instruction_register[0];
                     end else if (s_q.instruction_register[B_HOME]) begin
                        s_d.address_counter = 7'h00;
                        s_d.start_addr      = 7'h00;
                        s_d.glyph_sel       = 1'b0;
                     end else if (s_q.instruction_register[B_CLEAR]) begin
                        s_d.phase = S_CLEAR;
                        s_d.cnt   = 7'h00;
                     end
                  end
               endcase
               if (step_ac) begin
                  s_d.address_counter = step(s_q.address_counter, step_up,
                                             s_q.two_line, s_q.glyph_sel);
               end
            end
         end
         S_CLEAR: begin
            // One word per cycle keeps the memory single-ported.
            mem_we    = 1'b1;
            mem_cg    = 1'b0;
            mem_addr  = s_q.cnt;
            mem_wdata = SPACE_CODE;
            s_d.cnt   = 7'(s_q.cnt + 7'h01);
            if (s_q.cnt == CLR_LAST) begin
               s_d.phase           = S_LOAD;
               s_d.address_counter = 7'h00;
               s_d.start_addr      = 7'h00;
               s_d.glyph_sel       = 1'b0;
               s_d.increment_direction = 1'b1;
            end
         end
         S_LOAD: begin
            s_d.host_read_buffer = mem_rdata;
            s_d.phase            = S_IDLE;
         end
         default: begin
            s_d.phase = S_IDLE;
         end
      endcase

      // Read data is registered; four-bit reads present the selected nibble high.
      if (sel_now == SEL_STATUS) begin
         s_d.dout = {s_q.phase != S_IDLE, s_q.address_counter};
      end else begin
         s_d.dout = s_q.host_read_buffer;
      end
      if (!s_q.bus_width_bit && s_d.nib_low) begin
         s_d.dout = {s_d.dout[3:0], 4'hF};
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q                     <= '0;
         s_q.phase               <= S_CLEAR;
         s_q.bus_width_bit       <= 1'b1;
         s_q.increment_direction <= 1'b1;
         s_q.sel                 <= SEL_DREAD;
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge clock_i) begin
      if (mem_we && mem_cg) begin
         glyph_ram[mem_addr[5:0]] <= mem_wdata;
      end
      if (mem_we && !mem_cg) begin
         display_ram[dd_index(mem_addr, s_q.two_line)] <= mem_wdata;
      end
      refresh_data_o <= display_ram[dd_index(refresh_addr_i, s_q.two_line)];
   end

   assign busy_flag_o             = (s_q.phase != S_IDLE);
   assign host_data_bus_o         = s_q.dout;
   assign host_data_bus_oe_o      = {{4{host_i.enable & host_i.read_write}},
                                     {4{host_i.enable & host_i.read_write & s_q.bus_width_bit}}};
   assign cfg_o = '{two_line: s_q.two_line, font_tall: s_q.font_tall,
                    glyph_page: s_q.page, invert: s_q.invert, extended: extended,
                    display_cursor_blink: s_q.disp, start_address: s_q.start_addr,
                    cursor_address: s_q.address_counter};

   sequence idle_write_fall;
      (s_q.phase == S_IDLE) && xfer_done && sel_now == SEL_INSTR;
   endsequence

   chk_status_no_start: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (s_q.phase == S_IDLE) && fall && sel_now == SEL_STATUS |=> !busy_flag_o)
      else $error("status read started execution");
   chk_write_sets_busy: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      idle_write_fall |=> busy_flag_o && s_q.instruction_register == $past(xfer_byte))
      else $error("instruction write did not raise busy");
   chk_first_nibble_waits: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (s_q.phase == S_IDLE) && !s_q.bus_width_bit && fall && !s_q.nib_low && !sel_change
      |=> !busy_flag_o && s_q.nib_low)
      else $error("busy rose after first nibble");
   chk_select_resets_nib: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      sel_change && !fall |=> !s_q.nib_low)
      else $error("nibble selector not reset by select change");
   chk_regs_locked: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      busy_flag_o ##1 busy_flag_o |-> $stable(s_q.instruction_register)
      && $stable(s_q.host_write_buffer))
      else $error("interface register changed while busy");
   chk_exec_bounded: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      $rose(s_q.phase == S_EXEC) && s_q.op != OP_INSTR |-> ##[1:6] s_q.phase == S_LOAD
      ##1 s_q.host_read_buffer == $past(mem_rdata))
      else $error("read buffer not reloaded after execution");
   chk_clear_zeroes: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      $fell(s_q.phase == S_CLEAR) |-> s_q.address_counter == 7'h00 && s_q.start_addr == 7'h00)
      else $error("clear left counters nonzero");
   chk_two_line_jump: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      step_ac && step_up && s_q.two_line && !s_q.glyph_sel && s_q.address_counter == L1_LAST
      |=> s_q.address_counter == L2_FIRST)
      else $error("two-line order missed 39 to 64");
   chk_one_line_wrap: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      step_ac && !step_up && !s_q.two_line && !s_q.glyph_sel && s_q.address_counter == 7'h00
      |=> s_q.address_counter == ONE_LAST)
      else $error("one-line order missed 0 to 79");
   chk_glyph_wrap: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      step_ac && step_up && s_q.glyph_sel && s_q.address_counter == 7'h7F
      |=> s_q.address_counter == 7'h00)
      else $error("glyph counter did not wrap at 127");
endmodule
`default_nettype wire

// File: lcd_port_pkg.sv
`default_nettype none
package lcd_port_pkg;
   // Clock and execution timing.
   localparam int unsigned CLK_NS      = 100;
   localparam int unsigned EXEC_NS     = 400;
   localparam int unsigned EXEC_CYC    = (EXEC_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [6:0]  EXEC_LAST   = 7'(EXEC_CYC - 1);

   // Display memory layout and wrap points.
   localparam int unsigned DD_WORDS    = 80;
   localparam int unsigned CG_WORDS    = 64;
   localparam logic [6:0]  ONE_LAST    = 7'h4F;
   localparam logic [6:0]  L1_LAST     = 7'h27;
   localparam logic [6:0]  L2_FIRST    = 7'h40;
   localparam logic [6:0]  L2_LAST     = 7'h67;
   localparam logic [6:0]  L2_OFFSET   = 7'h18;
   localparam logic [6:0]  CLR_LAST    = 7'h4F;
   localparam logic [7:0]  SPACE_CODE  = 8'h20;

   // Select decode {register_select, read_write}.
   localparam logic [1:0]  SEL_INSTR   = 2'h0;
   localparam logic [1:0]  SEL_STATUS  = 2'h1;
   localparam logic [1:0]  SEL_DWRITE  = 2'h2;
   localparam logic [1:0]  SEL_DREAD   = 2'h3;

   // Instruction field positions.
   localparam int unsigned B_CLEAR     = 0;
   localparam int unsigned B_HOME      = 1;
   localparam int unsigned B_ENTRY     = 2;
   localparam int unsigned B_DISP      = 3;
   localparam int unsigned B_SHIFT     = 4;
   localparam int unsigned B_FUNC      = 5;
   localparam int unsigned B_CGADDR    = 6;
   localparam int unsigned B_DDADDR    = 7;

   typedef enum logic [1:0] {OP_INSTR, OP_DWRITE, OP_DREAD} op_t;
   typedef enum {S_IDLE, S_EXEC, S_CLEAR, S_LOAD} phase_t;

   typedef struct packed {
      logic       register_select;
      logic       read_write;
      logic       enable;
      logic [7:0] host_data_bus;
   } host_in_t;

   typedef struct packed {
      logic       two_line;
      logic       font_tall;
      logic       glyph_page;
      logic       invert;
      logic       extended;
      logic [2:0] display_cursor_blink;
      logic [6:0] start_address;
      logic [6:0] cursor_address;
   } display_cfg_t;
endpackage
`default_nettype wire

// File: tb_top.sv
`default_nettype none
`define CHK(nm, ex, got) \
   begin total_checks++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import lcd_port_pkg::*;
   logic         clock_i = 1'b0;
   logic         rst_b_i;
   host_in_t     host;
   logic [7:0]   dout;
   logic [7:0]   doe;
   logic         busy;
   logic         pin;
   logic [6:0]   raddr;
   logic [7:0]   rdata_o;
   display_cfg_t cfg;
   logic         four;
   logic [7:0]   rd;
   int           n_mismatch;
   int           total_checks;

   always #50 clock_i = ~clock_i;

   lcd_host_port i_dut (
      .clock_i            (clock_i),
      .rst_b_i            (rst_b_i),
      .host_i             (host),
      .host_data_bus_o    (dout),
      .host_data_bus_oe_o (doe),
      .busy_flag_o        (busy),
      .feature_mode_pin_i (pin),
      .refresh_addr_i     (raddr),
      .refresh_data_o     (rdata_o),
      .cfg_o              (cfg)
   );

   lcd_host_model i_host (
      .clock_i    (clock_i),
      .host_o     (host),
      .dev_data_i (dout),
      .dev_oe_i   (doe)
   );

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Busy rises on the first rising edge after the strobe falls; three cycles still pass before polling.
   task automatic wait_idle();
      int k;
      k = 0;
      repeat (3) @(negedge clock_i);
      while (busy !== 1'b0 && k < 300) begin
         @(negedge clock_i);
         k++;
      end
      if (k >= 300) begin
         n_mismatch++;
         $display("BAD busy_wait exp 0 got 1");
         test_done();
      end
   endtask

   task automatic instr(input logic [7:0] v);
      i_host.xfer(1'b0, 1'b0, v, four, rd);
      wait_idle();
   endtask

   task automatic wdata(input logic [7:0] v);
      i_host.xfer(1'b1, 1'b0, v, four, rd);
      wait_idle();
   endtask

   task automatic rdata();
      i_host.xfer(1'b1, 1'b1, 8'hFF, four, rd);
      wait_idle();
   endtask

   task automatic chk_ac(input logic [6:0] ex);
      i_host.xfer(1'b0, 1'b1, 8'hFF, four, rd);
      `CHK("status", {1'b0, ex}, rd)
      `CHK("cursor", ex, cfg.cursor_address)
   endtask

   task automatic refresh_chk(input logic [6:0] a, input logic [7:0] ex);
      raddr = a;
      repeat (2) @(negedge clock_i);
      `CHK("refresh", ex, rdata_o)
   endtask

   task automatic sc_reset();
      `CHK("busy_in_reset", 1'b1, busy)
      wait_idle();
      chk_ac(7'h00);
      `CHK("one_line", 1'b0, cfg.two_line)
      refresh_chk(7'h4F, 8'h20);
   endtask

   task automatic sc_one_line();
      instr(8'hCF);
      wdata(8'hA5);
      chk_ac(7'h00);
      instr(8'hCF);
      rdata();
      `CHK("read_buf", 8'hA5, rd)
      chk_ac(7'h00);
      instr(8'hFF);
      wdata(8'h11);
      chk_ac(7'h00);
      instr(8'h04);
      instr(8'h80);
      wdata(8'h22);
      chk_ac(7'h4F);
      refresh_chk(7'h00, 8'h22);
      refresh_chk(7'h4F, 8'hA5);
      instr(8'h06);
      instr(8'h01);
      chk_ac(7'h00);
      `CHK("start_clear", 7'h00, cfg.start_address)
      refresh_chk(7'h00, 8'h20);
   endtask

   task automatic sc_lock();
      i_host.xfer(1'b0, 1'b0, 8'h90, four, rd);
      i_host.xfer(1'b0, 1'b0, 8'hA0, four, rd);
      wait_idle();
      chk_ac(7'h10);
      i_host.xfer(1'b0, 1'b0, 8'h80, four, rd);
      @(negedge clock_i);
      i_host.xfer(1'b0, 1'b1, 8'hFF, four, rd);
      `CHK("busy_bit", 1'b1, rd[7])
      wait_idle();
      chk_ac(7'h00);
      repeat (3) @(negedge clock_i);
      `CHK("busy_after_status", 1'b0, busy)
   endtask

   task automatic sc_two_line();
      instr(8'h38);
      `CHK("two_line", 1'b1, cfg.two_line)
      instr(8'hA7);
      wdata(8'h01);
      chk_ac(7'h40);
      instr(8'hE7);
      wdata(8'h02);
      chk_ac(7'h00);
      instr(8'h04);
      instr(8'hC0);
      wdata(8'h5A);
      chk_ac(7'h27);
      refresh_chk(7'h40, 8'h5A);
      instr(8'h14);
      chk_ac(7'h40);
      instr(8'h18);
      `CHK("start_shift", 7'h67, cfg.start_address)
      instr(8'h80);
      wdata(8'h03);
      chk_ac(7'h67);
      instr(8'h02);
      chk_ac(7'h00);
      `CHK("start_home", 7'h00, cfg.start_address)
      instr(8'h06);
      instr(8'h1C);
      `CHK("start_up", 7'h01, cfg.start_address)
      instr(8'h30);
   endtask

   task automatic sc_glyph();
      instr(8'h7F);
      wdata(8'h3C);
      chk_ac(7'h40);
      instr(8'h04);
      instr(8'h40);
      wdata(8'h00);
      chk_ac(7'h7F);
      instr(8'h06);
      rdata();
      `CHK("glyph_top", 8'h3C, rd)
      chk_ac(7'h00);
      instr(8'h7F);
      rdata();
      `CHK("glyph_read", 8'h3C, rd)
      instr(8'h80);
   endtask

   task automatic sc_mode_pin();
      instr(8'h37);
      `CHK("font_tall", 1'b1, cfg.font_tall)
      `CHK("invert_std", 1'b0, cfg.invert)
      `CHK("page_std", 1'b0, cfg.glyph_page)
      `CHK("ext_std", 1'b0, cfg.extended)
      pin = 1'b0;
      instr(8'h37);
      `CHK("invert_ext", 1'b1, cfg.invert)
      `CHK("page_ext", 1'b1, cfg.glyph_page)
      `CHK("ext_ext", 1'b1, cfg.extended)
      instr(8'h30);
      `CHK("font_short", 1'b0, cfg.font_tall)
      `CHK("invert_off", 1'b0, cfg.invert)
      pin = 1'b1;
      instr(8'h0F);
      `CHK("disp_on", 3'h7, cfg.display_cursor_blink)
      instr(8'h08);
      `CHK("disp_off", 3'h0, cfg.display_cursor_blink)
   endtask

   task automatic sc_four_bit();
      instr(8'h20);
      four = 1'b1;
      i_host.pulse(1'b0, 1'b0, 8'h8F, rd);
      repeat (3) @(negedge clock_i);
      `CHK("busy_half", 1'b0, busy)
      i_host.pulse(1'b0, 1'b0, 8'h5F, rd);
      repeat (3) @(negedge clock_i);
      `CHK("busy_full", 1'b1, busy)
      wait_idle();
      chk_ac(7'h05);
      // A lone stray nibble must not shift the pairing of the next byte.
      i_host.pulse(1'b1, 1'b0, 8'hFF, rd);
      instr(8'h8A);
      chk_ac(7'h0A);
      wdata(8'h3C);
      chk_ac(7'h0B);
      instr(8'h8A);
      rdata();
      `CHK("read_4bit", 8'h3C, rd)
   endtask

   initial begin
      rst_b_i = 1'b0;
      pin = 1'b1;
      raddr = 7'h00;
      four = 1'b0;
      n_mismatch = 0;
      total_checks = 0;
      repeat (5) @(negedge clock_i);
      // One process drives the host model, so scenarios never overlap on the bus.
      sc_reset();
      sc_one_line();
      sc_lock();
      sc_two_line();
      sc_glyph();
      sc_mode_pin();
      sc_four_bit();
      test_done();
   end

   initial begin
      repeat (5) @(negedge clock_i);
      #1;
      rst_b_i = 1'b1;
   end
endmodule
`default_nettype wire
